// ---- verification/scan_engine_model.sv ----
// Scan engine model: plays the ladder program on the unit's register port.
// Assumes read data arrive in the cycle after the read strobe, and only there.
`timescale 1ns/1ps
module scan_engine_model (
  input wire logic core_clk, // Core clock
  output logic [shift_unit_pkg::ADDR_W-1:0] bus_addr, // Byte address
  output logic [shift_unit_pkg::DATA_W-1:0] bus_wdata, // Write data
  output logic bus_wr, // Write strobe
  output logic bus_rd, // Read strobe
  input wire logic [shift_unit_pkg::DATA_W-1:0] bus_rdata // Read data
);
  import shift_unit_pkg::*;
  logic prev_contact; // Raw shift contact seen at the previous scan, zero if that scan had no edge contact

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 32'h00000000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    prev_contact = 1'b0;
  end

  // Write data are scrambled on release so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  // One scan: present inputs, then fire the opcode; an edge contact is optional
  task automatic scan(input logic [1:0] op, input ctrl_t raw, input logic edge_det,
                      output ctrl_t sent);
    sent = raw;
    if (edge_det) begin
      sent.uni_shift = raw.uni_shift & ~prev_contact;
      sent.bi_shift = raw.bi_shift & ~prev_contact;
    end
    prev_contact = edge_det & (raw.uni_shift | raw.bi_shift);
    wr(OFF_CTRL, {24'h000000, sent});
    wr(OFF_SCAN, {30'h00000000, op});
  endtask : scan
endmodule : scan_engine_model

// ---- verification/tb_bit_table_shift_rotate_unit.sv ----
// Self-checking bench for the shift and rotate unit through its register port.
// Assumes the scan engine model in the same folder drives every bus cycle.
`timescale 1ns/1ps
module tb_bit_table_shift_rotate_unit;
  import shift_unit_pkg::*;
  logic core_clk;
  logic rst_n;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [DATA_W-1:0] bus_rdata;
  logic carry_flag_device;
  logic [63:0] eu;
  logic [63:0] eb;
  logic [15:0] ew;
  logic ec;
  logic ou;
  logic ob;
  logic orr;
  int nu;
  int nb;
  int num_errors = 0;
  int total_checks = 0;

  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  bit_table_shift_rotate_unit dut (.core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .carry_flag_device(carry_flag_device));
  scan_engine_model scan_eng (.core_clk(core_clk), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  function automatic logic [63:0] mask(input int n);
    return {64{1'b1}} >> (64 - n);
  endfunction : mask

  task automatic results;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    scan_eng.rd(a, d);
    chk(d, exp);
  endtask : rchk

  // Reference of all three instructions, then a full readback of the state
  task automatic run(input logic [1:0] op, input logic [7:0] raw, input logic edge_det);
    ctrl_t c;
    scan_eng.scan(op, ctrl_t'(raw), edge_det, c);
    if (op == OP_UNI && !c.uni_en) begin
      {eu, ec, ou} = '0;
    end else if (op == OP_UNI) begin
      if (c.uni_shift) begin
        ec = eu[nu-1];
        eu = ((eu << 1) | {63'h0, c.uni_data}) & mask(nu);
      end
      ou = eu[nu-1];
    end else if (op == OP_BI && !c.bi_en) begin
      {eb, ec, ob} = '0;
    end else if (op == OP_BI && c.bi_shift && c.bi_dir) begin
      ec = eb[nb-1];
      eb = ((eb << 1) | {63'h0, c.bi_data}) & mask(nb);
      ob = eb[nb-1];
    end else if (op == OP_BI && c.bi_shift) begin
      ec = eb[0];
      eb = (eb >> 1) | ({63'h0, c.bi_data} << (nb - 1));
      ob = eb[0];
    end else if (op == OP_BI) begin
      ob = eb[nb-1];
    end else if (c.rot_in) begin
      ec = ew[0];
      ew = {ew[0], ew[15:1]};
    end
    if (op == OP_ROT) orr = c.rot_in & ew[0];
    rchk(OFF_STATUS, {28'h0000000, ec, orr, ob, ou});
    rchk(OFF_UNI_LO, eu[31:0]);
    rchk(OFF_UNI_HI, eu[63:32]);
    rchk(OFF_BI_LO, eb[31:0]);
    rchk(OFF_BI_HI, eb[63:32]);
    rchk(OFF_WORD, {16'h0000, ew});
    chk({31'h0, carry_flag_device}, {31'h0, ec});
  endtask : run

  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {eu, eb, ew, ec, ou, ob, orr} = '0;
    nu = 1;
    nb = 1;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(OFF_CTRL, 32'h00000000);
    rchk(OFF_CFG, 32'h00000000);
    rchk(OFF_STATUS, 32'h00000000);
    rchk(8'h24, 32'h00000000);
    rchk(OFF_SCAN, 32'h00000000);
    run(OP_UNI, 8'h07, 1'b0);
    run(OP_UNI, 8'h03, 1'b0);
    run(OP_UNI, 8'h00, 1'b0);
    scan_eng.wr(OFF_CFG, 32'h0000083f);
    nu = 64;
    nb = 9;
    rchk(OFF_CFG, 32'h0000083f);
    // Long level shift pushes ones out of the top into carry
    for (int i = 0; i < 70; i++) begin
      run(OP_UNI, 8'h03 | {5'h00, i[0] ^ i[3], 2'h0}, 1'b0);
    end
    run(OP_UNI, 8'h01, 1'b0);
    for (int i = 0; i < 3; i++) begin
      run(OP_UNI, 8'h07, 1'b1);
    end
    for (int i = 0; i < 12; i++) begin
      run(OP_BI, 8'h58 | {2'h0, i[0] | i[2], 5'h00}, 1'b0);
    end
    for (int i = 0; i < 12; i++) begin
      run(OP_BI, 8'h18 | {2'h0, i[1], 5'h00}, 1'b0);
    end
    run(OP_BI, 8'h08, 1'b0);
    run(OP_UNI, 8'h01, 1'b0);
    run(OP_BI, 8'h00, 1'b0);
    run(OP_UNI, 8'h00, 1'b0);
    scan_eng.wr(OFF_WORD, 32'h00008005);
    ew = 16'h8005;
    for (int i = 0; i < 17; i++) begin
      run(OP_ROT, 8'h80, 1'b0);
    end
    run(OP_ROT, 8'h00, 1'b0);
    run(OP_UNI, 8'h01, 1'b0);
    scan_eng.wr(OFF_SCAN, 32'h00000000);
    scan_eng.wr(OFF_STATUS, 32'h0000000f);
    rchk(OFF_STATUS, {28'h0000000, ec, orr, ob, ou});
    results();
  end
endmodule : tb_bit_table_shift_rotate_unit

// ---- verilog/bit_table_shift_rotate_unit.sv ----
// Top of the bit-table shift and word-rotate unit with its register port.
// Assumes a bus master that issues single-cycle read or write strobes.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module bit_table_shift_rotate_unit (
  input wire logic core_clk, // Core clock, 50 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [shift_unit_pkg::ADDR_W-1:0] bus_addr, // Byte address
  input wire logic [shift_unit_pkg::DATA_W-1:0] bus_wdata, // Write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  output logic [shift_unit_pkg::DATA_W-1:0] bus_rdata, // Read data, next cycle
  output logic carry_flag_device // Shared carry flag
);
  import shift_unit_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ctrl_t ctrl_reg;
  status_t status;
  logic [LEN_W-1:0] uni_len_reg;
  logic [LEN_W-1:0] bi_len_reg;
  logic carry_flag;
  logic scan_wr;
  logic uni_exec;
  logic bi_exec;
  logic rot_exec;
  logic word_wr;
  logic [TABLE_MAX-1:0] uni_tbl;
  logic [TABLE_MAX-1:0] bi_tbl;
  logic [WORD_W-1:0] rot_word;
  logic uni_out;
  logic bi_out;
  logic rot_out;
  logic uni_cwe;
  logic uni_cval;
  logic bi_cwe;
  logic bi_cval;
  logic rot_cwe;
  logic rot_cval;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // A scan write runs at most one instruction, so carry writers never collide
  assign scan_wr = bus_wr && (bus_addr == OFF_SCAN);
  assign uni_exec = scan_wr && (bus_wdata[1:0] == OP_UNI);
  assign bi_exec = scan_wr && (bus_wdata[1:0] == OP_BI);
  assign rot_exec = scan_wr && (bus_wdata[1:0] == OP_ROT);
  assign word_wr = bus_wr && (bus_addr == OFF_WORD);

  // Instruction inputs, as the scan engine presents them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
    end else if (bus_wr && bus_addr == OFF_CTRL) begin
      ctrl_reg <= bus_wdata[7:0];
    end
  end

  // Table sizes, stored as n minus one so every code is a legal size
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      uni_len_reg <= LEN_RST;
      bi_len_reg <= LEN_RST;
    end else if (bus_wr && bus_addr == OFF_CFG) begin
      uni_len_reg <= bus_wdata[CFG_UNI_LSB +: LEN_W];
      bi_len_reg <= bus_wdata[CFG_BI_LSB +: LEN_W];
    end
  end

  // ----------------------------------------
  // Instruction units
  // ----------------------------------------
  // One-way table always shifts toward higher addresses
  table_shifter u_uni (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .exec(uni_exec),
    .enable(ctrl_reg.uni_en),
    .shift(ctrl_reg.uni_shift),
    .data_in(ctrl_reg.uni_data),
    .up(1'b1),
    .len_m1(uni_len_reg),
    .table_reg(uni_tbl),
    .out_reg(uni_out),
    .carry_we(uni_cwe),
    .carry_val(uni_cval)
  );

  // Two-way table follows the direction input
  table_shifter u_bi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .exec(bi_exec),
    .enable(ctrl_reg.bi_en),
    .shift(ctrl_reg.bi_shift),
    .data_in(ctrl_reg.bi_data),
    .up(ctrl_reg.bi_dir),
    .len_m1(bi_len_reg),
    .table_reg(bi_tbl),
    .out_reg(bi_out),
    .carry_we(bi_cwe),
    .carry_val(bi_cval)
  );

  word_rotator u_rot (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .exec(rot_exec),
    .rot_in(ctrl_reg.rot_in),
    .wr_en(word_wr),
    .wr_data(bus_wdata[WORD_W-1:0]),
    .word_reg(rot_word),
    .out_reg(rot_out),
    .carry_we(rot_cwe),
    .carry_val(rot_cval)
  );

  // ----------------------------------------
  // Shared carry flag
  // ----------------------------------------
  // Only one writer can be active per cycle, since one opcode is decoded
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      carry_flag <= 1'b0;
    end else if (uni_cwe) begin
      carry_flag <= uni_cval;
    end else if (bi_cwe) begin
      carry_flag <= bi_cval;
    end else if (rot_cwe) begin
      carry_flag <= rot_cval;
    end
  end

  assign carry_flag_device = carry_flag;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  assign status = '{carry: carry_flag, rot_out: rot_out, bi_out: bi_out, uni_out: uni_out};

  // Data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_rdata <= '0;
    end else if (!bus_rd) begin
      bus_rdata <= '0;
    end else begin
      case (bus_addr)
        OFF_CTRL: bus_rdata <= {24'h000000, ctrl_reg};
        OFF_CFG: bus_rdata <= {18'h00000, bi_len_reg, 2'h0, uni_len_reg};
        OFF_STATUS: bus_rdata <= {28'h0000000, status};
        OFF_UNI_LO: bus_rdata <= uni_tbl[31:0];
        OFF_UNI_HI: bus_rdata <= uni_tbl[63:32];
        OFF_BI_LO: bus_rdata <= bi_tbl[31:0];
        OFF_BI_HI: bus_rdata <= bi_tbl[63:32];
        OFF_WORD: bus_rdata <= {16'h0000, rot_word};
        default: bus_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_uni_shift;
    uni_exec && ctrl_reg.uni_en && ctrl_reg.uni_shift;
  endsequence

  sequence s_bi_down;
    bi_exec && ctrl_reg.bi_en && ctrl_reg.bi_shift && !ctrl_reg.bi_dir;
  endsequence

  sequence s_bi_up;
    bi_exec && ctrl_reg.bi_en && ctrl_reg.bi_shift && ctrl_reg.bi_dir;
  endsequence

  a_uni_shift_carry: assert property (
    s_uni_shift |=> carry_flag == $past(uni_tbl[uni_len_reg])
  ) else $error("one-way shift lost its top bit");

  a_uni_data_in: assert property (
    s_uni_shift |=> uni_tbl[0] == $past(ctrl_reg.uni_data)
  ) else $error("one-way shift did not load data bit");

  a_uni_clear_all: assert property (
    uni_exec && !ctrl_reg.uni_en |=> uni_tbl == '0 && !carry_flag && !uni_out
  ) else $error("one-way disable did not clear");

  a_uni_out_last: assert property (
    uni_exec && ctrl_reg.uni_en |=> uni_out == uni_tbl[uni_len_reg]
  ) else $error("one-way output not top bit");

  a_uni_carry_hold: assert property (
    uni_exec && ctrl_reg.uni_en && !ctrl_reg.uni_shift |=> $stable(carry_flag)
  ) else $error("carry moved without shift");

  // Checked at every enabled scan with shift on, so a held input must keep shifting
  a_level_shift_repeat: assert property (
    s_uni_shift |=> uni_tbl == ((($past(uni_tbl) << 1)
      | {{(TABLE_MAX-1){1'b0}}, $past(ctrl_reg.uni_data)}) & len_mask($past(uni_len_reg)))
  ) else $error("held shift input did not shift again");

  a_bi_down_step: assert property (
    s_bi_down |=> carry_flag == $past(bi_tbl[0])
      && bi_tbl[bi_len_reg] == $past(ctrl_reg.bi_data)
  ) else $error("two-way down shift wrong");

  a_bi_up_step: assert property (
    s_bi_up |=> carry_flag == $past(bi_tbl[bi_len_reg])
      && bi_tbl[0] == $past(ctrl_reg.bi_data)
  ) else $error("two-way up shift wrong");

  a_bi_clear_all: assert property (
    bi_exec && !ctrl_reg.bi_en |=> bi_tbl == '0 && !carry_flag && !bi_out
  ) else $error("two-way disable did not clear");

  a_bi_out_select: assert property (
    s_bi_down |=> bi_out == bi_tbl[0]
  ) else $error("two-way output not lowest bit");

  a_bi_out_high: assert property (
    bi_exec && ctrl_reg.bi_en && !(ctrl_reg.bi_shift && !ctrl_reg.bi_dir)
      |=> bi_out == bi_tbl[bi_len_reg]
  ) else $error("two-way output not highest bit");

  a_rot_word_step: assert property (
    rot_exec && ctrl_reg.rot_in |=> rot_word == {$past(rot_word[0]), $past(rot_word[15:1])}
      && carry_flag == $past(rot_word[0])
  ) else $error("rotate right wrong");

  a_rot_off_idle: assert property (
    rot_exec && !ctrl_reg.rot_in |=> !rot_out && $stable(rot_word) && $stable(carry_flag)
  ) else $error("rotate ran with input off");

  a_rot_out_lsb: assert property (
    rot_exec && ctrl_reg.rot_in |=> rot_out == rot_word[0]
  ) else $error("rotate output not new lsb");

  // ----------------------------------------
  // Whole-table and bookkeeping checks
  // ----------------------------------------
  // End-bit checks alone would miss a bit dropped in the middle of a table
  a_uni_upper_clear: assert property (
    uni_exec |=> (uni_tbl & ~len_mask(uni_len_reg)) == '0
  ) else $error("one-way bits above table size not clear");

  a_bi_upper_clear: assert property (
    bi_exec |=> (bi_tbl & ~len_mask(bi_len_reg)) == '0
  ) else $error("two-way bits above table size not clear");

  a_bi_up_table: assert property (
    s_bi_up |=> bi_tbl == ((($past(bi_tbl) << 1)
      | {{(TABLE_MAX-1){1'b0}}, $past(ctrl_reg.bi_data)}) & len_mask($past(bi_len_reg)))
  ) else $error("two-way table not shifted up by one");

  a_bi_down_table: assert property (
    s_bi_down |=> bi_tbl == ((($past(bi_tbl) & len_mask($past(bi_len_reg))) >> 1)
      | ({{(TABLE_MAX-1){1'b0}}, $past(ctrl_reg.bi_data)} << $past(bi_len_reg)))
  ) else $error("two-way table not shifted down by one");

  // An enabled scan with shift off keeps the table, only masked to its current size
  a_uni_hold_table: assert property (
    uni_exec && ctrl_reg.uni_en && !ctrl_reg.uni_shift
      |=> uni_tbl == ($past(uni_tbl) & len_mask($past(uni_len_reg)))
  ) else $error("one-way table moved without shift");

  a_bi_hold_table: assert property (
    bi_exec && ctrl_reg.bi_en && !ctrl_reg.bi_shift
      |=> bi_tbl == ($past(bi_tbl) & len_mask($past(bi_len_reg)))
  ) else $error("two-way table moved without shift");

  a_bi_carry_hold: assert property (
    bi_exec && ctrl_reg.bi_en && !ctrl_reg.bi_shift |=> $stable(carry_flag)
  ) else $error("carry moved without two-way shift");

  // Between scans only a word load may move state, however long the program takes
  a_tables_no_scan: assert property (
    !uni_exec && !bi_exec |=> $stable(uni_tbl) && $stable(bi_tbl)
  ) else $error("table moved outside a scan");

  a_outs_no_scan: assert property (
    !scan_wr |=> $stable(uni_out) && $stable(bi_out) && $stable(rot_out)
      && $stable(carry_flag)
  ) else $error("output or carry moved outside a scan");

  a_word_no_scan: assert property (
    !rot_exec && !word_wr |=> $stable(rot_word)
  ) else $error("word moved outside a rotate or load");

  a_word_load: assert property (
    word_wr |=> rot_word == $past(bus_wdata[WORD_W-1:0])
  ) else $error("word load lost bits");

  // One opcode per scan write keeps the shared carry free of collisions
  a_carry_one_writer: assert property (
    $onehot0({uni_cwe, bi_cwe, rot_cwe})
  ) else $error("two carry writers in one cycle");

  // Read data stand for the one cycle after the strobe only
  a_rdata_idle_zero: assert property ( // Bus read timing
    !bus_rd |=> bus_rdata == '0
  ) else $error("read data stood without a strobe");

endmodule : bit_table_shift_rotate_unit

// ---- verilog/shift_unit_pkg.sv ----
// Constants, register layout and carriers for the bit-table shift/rotate unit.
// Assumes one core clock and a plain strobe-style register port.
// ----------------------------------------------------------------------------
// Summary of operation
// - Enabled one-way shift moves n-bit table up; top bit goes to carry.
// - Each one-way shift loads data input into the lowest table bit.
// - One-way enable off clears table and carry; output reads off.
// - One-way output shows top table bit; carry kept when not shifting.
// - Shift input is a level: one shift per scan while it is on.
// - Two-way shift: direction off moves down, on moves up; lost bit to carry.
// - Two-way data enters top bit going down, lowest bit going up.
// - Two-way enable off clears table and carry; output off.
// - Two-way output: lowest bit after down shift, else highest bit.
// - Rotate right one: lsb copied to msb and carry; input off gives output off.
// - After rotating, output on exactly when new lsb is one.
// ----------------------------------------------------------------------------
package shift_unit_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TABLE_MAX = 64;
  localparam int LEN_W = 6;
  localparam int WORD_W = 16;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SCAN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_UNI_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_UNI_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_BI_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_BI_HI = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_WORD = 8'h20;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CFG_UNI_LSB = 0;
  localparam int CFG_BI_LSB = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [LEN_W-1:0] LEN_RST = 6'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // Scan opcodes written to OFF_SCAN bits [1:0]
  localparam logic [1:0] OP_UNI = 2'h1;
  localparam logic [1:0] OP_BI = 2'h2;
  localparam logic [1:0] OP_ROT = 2'h3;

  // Instruction inputs as seen by one scan
  typedef struct packed {
    logic rot_in;
    logic bi_dir;
    logic bi_data;
    logic bi_shift;
    logic bi_en;
    logic uni_data;
    logic uni_shift;
    logic uni_en;
  } ctrl_t;

  // Status word, low bits of OFF_STATUS
  typedef struct packed {
    logic carry;
    logic rot_out;
    logic bi_out;
    logic uni_out;
  } status_t;

  // Ones in the low n bits, n = len_m1 + 1
  function automatic logic [TABLE_MAX-1:0] len_mask(input logic [LEN_W-1:0] len_m1);
    return {TABLE_MAX{1'b1}} >> (6'h3f - len_m1);
  endfunction : len_mask

endpackage : shift_unit_pkg

// ---- verilog/table_shifter.sv ----
// One bit table of up to 64 devices with shift-by-one in either direction.
// Assumes exec is a one-cycle pulse per scan from logic on the same clock.
`timescale 1ns/1ps
module table_shifter (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic exec, // One scan evaluation
  input wire logic enable, // Enable input
  input wire logic shift, // Shift input, level
  input wire logic data_in, // Data input
  input wire logic up, // High: toward higher addresses
  input wire logic [shift_unit_pkg::LEN_W-1:0] len_m1, // Table size minus one
  output logic [shift_unit_pkg::TABLE_MAX-1:0] table_reg, // Table contents
  output logic out_reg, // Instruction output
  output logic carry_we, // Carry write this cycle
  output logic carry_val // Carry value to write
);
  import shift_unit_pkg::*;

  logic [TABLE_MAX-1:0] mask;
  logic [TABLE_MAX-1:0] live;
  logic [TABLE_MAX-1:0] table_next;
  logic out_next;

  // ----------------------------------------
  // Next table and output
  // ----------------------------------------
  // Bits beyond n are masked so a shrunk table never leaks stale bits
  always_comb begin
    mask = len_mask(len_m1);
    live = table_reg & mask;
    table_next = live;
    out_next = 1'b0;
    if (!enable) begin
      table_next = '0;
    end else if (shift && up) begin
      table_next = ((live << 1) | {{(TABLE_MAX-1){1'b0}}, data_in}) & mask;
      out_next = table_next[len_m1];
    end else if (shift) begin
      table_next = (live >> 1) | ({{(TABLE_MAX-1){1'b0}}, data_in} << len_m1);
      out_next = table_next[0];
    end else begin
      out_next = live[len_m1];
    end
  end

  // Carry is written on clear or shift; an enabled scan with no shift leaves it alone
  assign carry_we = exec && (!enable || shift);
  assign carry_val = enable && (up ? live[len_m1] : live[0]);

  // ----------------------------------------
  // Table and output registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      table_reg <= '0;
      out_reg <= 1'b0;
    end else if (exec) begin
      table_reg <= table_next;
      out_reg <= out_next;
    end
  end

endmodule : table_shifter

// ---- verilog/word_rotator.sv ----
// A 16-bit word with one-bit rotate right and software load.
// Assumes exec and wr_en never arrive in the same cycle.
`timescale 1ns/1ps
module word_rotator (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic exec, // One scan evaluation
  input wire logic rot_in, // Instruction input
  input wire logic wr_en, // Software load strobe
  input wire logic [shift_unit_pkg::WORD_W-1:0] wr_data, // Load value
  output logic [shift_unit_pkg::WORD_W-1:0] word_reg, // Word contents
  output logic out_reg, // Instruction output
  output logic carry_we, // Carry write this cycle
  output logic carry_val // Carry value to write
);
  import shift_unit_pkg::*;

  // Expelled lsb feeds msb and carry; input off writes no carry
  assign carry_we = exec && rot_in;
  assign carry_val = word_reg[0];

  // ----------------------------------------
  // Word and output
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      word_reg <= WORD_RST;
      out_reg <= 1'b0;
    end else if (exec) begin
      if (rot_in) begin
        word_reg <= {word_reg[0], word_reg[WORD_W-1:1]};
      end
      out_reg <= rot_in && word_reg[1];
    end else if (wr_en) begin
      word_reg <= wr_data;
    end
  end

endmodule : word_rotator
